// ==== rtl/uart_consts.vh ====
// uart_consts.vh: register map, fields and timing of the uart
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH
// register byte offsets
`define A_DATA 8'h00
`define A_STAT 8'h04
`define A_CTRL 8'h08
`define A_LINE 8'h0C
`define A_BAUD 8'h10
`define A_LVL  8'h14
`define A_IST  8'h18
`define A_IMSK 8'h1C
// control bits
`define C_GEN 0
`define C_TEN 1
`define C_REN 2
`define C_FEN 3
`define C_IR  4
`define C_LP  5
`define C_BRK 6
`define CTRL_RST 7'h00
// line fields and parity modes
`define L_WL  1:0
`define L_STP 2
`define L_PAR 5:3
`define LINE_RST 6'h03
`define P_NONE 3'h0
`define P_EVEN 3'h1
`define P_ODD  3'h2
`define P_ONE  3'h3
`define BAUD_RST 16'h0044
`define LVL_RST  6'h12
// interrupt bits
`define I_RX 0
`define I_TX 1
`define I_RT 2
`define I_FE 3
`define I_PE 4
`define I_BE 5
`define I_OE 6
// timing
`define OVS_LAST 4'hF
`define OVS_MID  4'h7
`define IR_PW_LAST 4'h2
`define IR_LP_NS 1630
`define CLK_MHZ 125
`define IR_LP_CYC ((`IR_LP_NS*`CLK_MHZ+999)/1000)
`define RT_PRE  10'h1FE
`define RT_LAST 10'h1FF
`define FIFO_FULL 5'h10
`endif

// ==== rtl/uart_core_control.v ====
// uart_core_control.v: apb uart with fifos, sir codec and interrupts
//
// Contract
// - enable sets global, tx, rx enables, fifos
// - disable finishes current tx character, flushes tx
// - five to eight data bits per frame
// - one or two stop bits selectable
// - parity none, even, odd, one, zero
// - infrared enable routes line through sir codec
// - low power bit selects short sir pulse
// - leaving infrared clears low power
// - tx/rx fifo thresholds, readable back
// - tx space status, full write refused
// - rx data available status
// - baud from clock, divisor readable
// - rx fifo 16x12, tx fifo 16x8
// - maskable overrun, break, parity, framing, timeout
`timescale 1ns/1ns
`include "uart_consts.vh"

// sixteen entry fifo, width set per use
module uart_fifo #(parameter W = 8) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         push,
  input  wire         pop,
  input  wire         flush,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout,
  output wire [4:0]   count
);
  reg [W-1:0] mem [0:15];   // storage
  reg [3:0]   wp_reg;       // write index
  reg [3:0]   rp_reg;       // read index
  reg [4:0]   cnt_reg;      // fill level
  assign dout  = mem[rp_reg];
  assign count = cnt_reg;
  // pointers; callers never push when full nor pop when empty
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else if (flush) begin
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else begin
      if (push) wp_reg <= wp_reg + 4'h1;
      if (pop) rp_reg <= rp_reg + 4'h1;
      if (push & ~pop) cnt_reg <= cnt_reg + 5'h01;
      else if (pop & ~push) cnt_reg <= cnt_reg - 5'h01;
    end
  end
  // data array has no reset, it is gated by the count
  always @(posedge clk) begin
    if (push & ~flush) mem[wp_reg] <= din;
  end
endmodule

module uart_core_control (
  // clock and reset
  input  wire        MCLK_IN,
  input  wire        RST_N_IN,
  // apb slave
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [7:0]  PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  // serial line and interrupt
  input  wire        RXD_IN,
  output reg         TXD_OUT,
  output reg         IRQ_OUT
);
  localparam T_IDLE = 5'h01, T_START = 5'h02, T_DATA = 5'h04;
  localparam T_PAR = 5'h08, T_STOP = 5'h10;
  localparam R_IDLE = 5'h01, R_START = 5'h02, R_DATA = 5'h04;
  localparam R_PAR = 5'h08, R_STOP = 5'h10;
  wire [31:0] lp_full = `IR_LP_CYC;     // sir short pulse in cycles

  reg [6:0]  ctrl_reg;                  // enables, sir, break
  reg [5:0]  line_reg;                  // length, stop, parity
  reg [15:0] baud_reg;                  // divisor of the 16x tick
  reg [5:0]  lvl_reg;                   // tx [2:0], rx [5:3] levels
  reg [6:0]  ist_reg;                   // sticky interrupt status
  reg [6:0]  imsk_reg;                  // interrupt mask
  reg [15:0] bcnt_reg;                  // baud divider count
  reg        tick_reg;                  // 16x oversample enable
  reg        rxa_reg, rxb_reg;          // rx pin synchroniser
  reg [4:0]  irh_reg;                   // sir decoder stretch
  reg [4:0]  tst_reg, rst_reg;          // tx and rx states
  reg [3:0]  tph_reg, rph_reg;          // tick within bit
  reg [2:0]  tbit_reg, rbit_reg;        // data bit index
  reg [7:0]  tsh_reg, rsh_reg;          // shift registers
  reg        tpar_reg, rpb_reg;         // parity out / parity in
  reg        tstp_reg;                  // second stop bit pending
  reg [7:0]  irc_reg;                   // low power pulse count
  reg [9:0]  rtc_reg;                   // receive timeout count
  reg        oep_reg;                   // overrun to tag next entry
  reg        txok_reg, rxok_reg;        // previous level compares
  reg        popok_reg;                 // rx entry shown at setup
  reg [6:0]  ist_next;

  wire gen = ctrl_reg[`C_GEN];
  wire fen = ctrl_reg[`C_FEN];
  wire ir  = ctrl_reg[`C_IR];
  wire [1:0] wl = line_reg[`L_WL];
  wire [2:0] pm = line_reg[`L_PAR];
  wire [2:0] nlast = {1'b0, wl} + 3'h4;   // last data bit index
  wire [1:0] rsh_amt = 2'h3 - wl;
  wire [7:0] wmask = 8'hFF >> rsh_amt;

  // parity of a masked character
  function par_of;
    input [7:0] d;
    input [2:0] m;
    begin
      case (m)
        `P_EVEN: par_of = ^d;
        `P_ODD:  par_of = ~^d;
        `P_ONE:  par_of = 1'b1;
        default: par_of = 1'b0;
      endcase
    end
  endfunction

  // fifo level code to entry count: 1/8,2/8,4/8,6/8,7/8 of 16
  function [4:0] thr_of;
    input [2:0] c;
    begin
      case (c)
        3'h0:    thr_of = 5'h02;
        3'h1:    thr_of = 5'h04;
        3'h2:    thr_of = 5'h08;
        3'h3:    thr_of = 5'h0C;
        default: thr_of = 5'h0E;
      endcase
    end
  endfunction

  // fifos
  wire [7:0]  txq;
  wire [11:0] rxq;
  wire [4:0]  txc, rxc;
  wire tx_full = fen ? (txc == `FIFO_FULL) : (txc != 5'h00);
  wire rx_full = fen ? (rxc == `FIFO_FULL) : (rxc != 5'h00);
  wire tx_empty = (txc == 5'h00);
  wire rx_empty = (rxc == 5'h00);

  // apb phases; access completes on the one wait-free cycle
  wire setup = PSEL_IN & ~PENABLE_IN;
  wire acc   = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire wr    = acc & PWRITE_IN;
  wire rd    = acc & ~PWRITE_IN;
  wire tx_push = wr & (PADDR_IN == `A_DATA) & ~PSLVERR_OUT;
  // pop only what the setup cycle showed; a frame landing between setup
  // and access in an empty fifo would otherwise be dropped unread
  wire rx_pop  = rd & (PADDR_IN == `A_DATA) & popok_reg;
  wire ist_rd  = rd & (PADDR_IN == `A_IST);

  // transmit control
  wire tx_idle = (tst_reg == T_IDLE);
  wire tx_go = tick_reg & tx_idle & gen & ctrl_reg[`C_TEN] & ~tx_empty;
  wire tx_flush = ~gen & tx_idle;
  wire bit_start = tx_go | (tick_reg & ~tx_idle & tph_reg == `OVS_LAST);

  // receive control
  wire rxl = ir ? (irh_reg == 5'h00) : rxb_reg;
  wire rx_on = gen & ctrl_reg[`C_REN];
  wire rx_end = tick_reg & (rst_reg == R_STOP) & (rph_reg == `OVS_LAST);
  wire [7:0] rdat = rsh_reg >> rsh_amt;
  wire fe = ~rxl;
  wire pe = (pm != `P_NONE) & (rpb_reg != par_of(rdat, pm));
  wire be = (rdat == 8'h00) & ~rxl & ((pm == `P_NONE) | ~rpb_reg);
  wire rx_push = rx_end & ~rx_full;
  wire oe_ev = rx_end & rx_full;
  wire rt_ev = tick_reg & (rtc_reg == `RT_PRE);

  // level events on the crossing of each threshold
  wire txok = (txc <= thr_of(lvl_reg[2:0]));
  wire rxok = (rxc >= thr_of(lvl_reg[5:3]));
  wire [6:0] ev = {oe_ev, rx_end & be, rx_end & pe, rx_end & fe,
                   rt_ev, txok & ~txok_reg, rxok & ~rxok_reg};

  uart_fifo #(.W(8)) u_txf (
    .clk(MCLK_IN), .rst_n(RST_N_IN), .push(tx_push), .pop(tx_go),
    .flush(tx_flush), .din(PWDATA_IN[7:0]), .dout(txq), .count(txc));
  uart_fifo #(.W(12)) u_rxf (
    .clk(MCLK_IN), .rst_n(RST_N_IN), .push(rx_push), .pop(rx_pop),
    .flush(1'b0), .din({oep_reg, be, pe, fe, rdat}), .dout(rxq),
    .count(rxc));

  // sticky status: a new event wins over the read clear
  always @* begin
    ist_next = (ist_reg & {7{~ist_rd}}) | ev;
  end

  // apb register file and answer
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_reg    <= `CTRL_RST;
      line_reg    <= `LINE_RST;
      baud_reg    <= `BAUD_RST;
      lvl_reg     <= `LVL_RST;
      imsk_reg    <= 7'h00;
      ist_reg     <= 7'h00;
      IRQ_OUT     <= 1'b0;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h00000000;
      popok_reg   <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      IRQ_OUT <= |(ist_next & imsk_reg);
      PREADY_OUT <= setup;
      if (setup) begin
        // read data and error are fixed in the setup cycle
        PSLVERR_OUT <= PWRITE_IN & (PADDR_IN == `A_DATA) & tx_full;
        // entries only grow until the access, so the head stays put
        popok_reg   <= ~rx_empty;
        case (PADDR_IN)
          `A_DATA: PRDATA_OUT <= {20'h00000, rx_empty ? 12'h000 : rxq};
          `A_STAT: PRDATA_OUT <= {28'h0000000, ~tx_idle, tx_empty,
                                  ~rx_empty, ~tx_full};
          `A_CTRL: PRDATA_OUT <= {25'h0000000, ctrl_reg};
          `A_LINE: PRDATA_OUT <= {26'h0000000, line_reg};
          `A_BAUD: PRDATA_OUT <= {16'h0000, baud_reg};
          `A_LVL:  PRDATA_OUT <= {26'h0000000, lvl_reg};
          // next value, so an event of the setup cycle is reported
          // before the access clears it
          `A_IST:  PRDATA_OUT <= {25'h0000000, ist_next};
          `A_IMSK: PRDATA_OUT <= {25'h0000000, imsk_reg};
          default: begin
            PRDATA_OUT  <= 32'h00000000;
            PSLVERR_OUT <= 1'b1;       // unmapped offset
          end
        endcase
      end
      if (wr) begin
        case (PADDR_IN)
          `A_CTRL: begin
            ctrl_reg <= PWDATA_IN[6:0];
            if (~PWDATA_IN[`C_IR])
              ctrl_reg[`C_LP] <= 1'b0;
          end
          `A_LINE: line_reg <= PWDATA_IN[5:0];
          `A_BAUD: baud_reg <= PWDATA_IN[15:0];
          `A_LVL:  lvl_reg <= PWDATA_IN[5:0];
          `A_IMSK: imsk_reg <= PWDATA_IN[6:0];
          default: ;
        endcase
      end
    end
  end

  // baud divider; a zero divisor stops the line
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bcnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (baud_reg == 16'h0000) begin
      bcnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (bcnt_reg >= baud_reg - 16'h0001) begin
      bcnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      bcnt_reg <= bcnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // transmitter; the current frame always completes
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tst_reg  <= T_IDLE;
      tph_reg  <= 4'h0;
      tbit_reg <= 3'h0;
      tsh_reg  <= 8'h00;
      tpar_reg <= 1'b0;
      tstp_reg <= 1'b0;
    end else if (tx_go) begin
      tst_reg  <= T_START;
      tph_reg  <= 4'h0;
      tsh_reg  <= txq & wmask;
      tpar_reg <= par_of(txq & wmask, pm);
    end else if (tick_reg & ~tx_idle) begin
      tph_reg <= tph_reg + 4'h1;
      if (tph_reg == `OVS_LAST) begin
        case (tst_reg)
          T_START: begin
            tst_reg  <= T_DATA;
            tbit_reg <= 3'h0;
          end
          T_DATA: begin
            tsh_reg  <= tsh_reg >> 1;
            tbit_reg <= tbit_reg + 3'h1;
            tstp_reg <= line_reg[`L_STP];
            if (tbit_reg == nlast)
              tst_reg <= (pm == `P_NONE) ? T_STOP : T_PAR;
          end
          T_PAR: tst_reg <= T_STOP;
          T_STOP: begin
            if (tstp_reg) tstp_reg <= 1'b0;
            else tst_reg <= T_IDLE;
          end
          default: tst_reg <= T_IDLE;
        endcase
      end
    end
  end

  // line bit before coding; break forces the line low
  reg nrz;
  always @* begin
    case (tst_reg)
      T_START: nrz = 1'b0;
      T_DATA:  nrz = tsh_reg[0];
      T_PAR:   nrz = tpar_reg;
      default: nrz = 1'b1;
    endcase
    if (ctrl_reg[`C_BRK]) nrz = 1'b0;
  end

  // sir encoder: a pulse for each zero bit, 3/16 or short
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irc_reg <= 8'h00;
      TXD_OUT <= 1'b1;
    end else begin
      if (bit_start) irc_reg <= lp_full[7:0];
      else if (irc_reg != 8'h00) irc_reg <= irc_reg - 8'h01;
      if (ir)
        TXD_OUT <= ~nrz & (ctrl_reg[`C_LP] ? (irc_reg != 8'h00)
                           : (tph_reg <= `IR_PW_LAST));
      else
        TXD_OUT <= nrz;
    end
  end

  // rx pin synchroniser and sir pulse stretcher
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rxa_reg <= 1'b1;
      rxb_reg <= 1'b1;
      irh_reg <= 5'h00;
    end else begin
      rxa_reg <= RXD_IN;
      rxb_reg <= rxa_reg;
      // a high pulse marks a zero bit for one bit time
      if (rxb_reg & ir) irh_reg <= 5'h10;
      else if (tick_reg & irh_reg != 5'h00) irh_reg <= irh_reg - 5'h01;
    end
  end

  // receiver, 16x oversampled, centre sampled
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_reg  <= R_IDLE;
      rph_reg  <= 4'h0;
      rbit_reg <= 3'h0;
      rsh_reg  <= 8'h00;
      rpb_reg  <= 1'b0;
    end else if (~rx_on) begin
      rst_reg <= R_IDLE;
    end else if (tick_reg) begin
      rph_reg <= rph_reg + 4'h1;
      case (rst_reg)
        R_IDLE: begin
          rph_reg <= 4'h0;
          if (~rxl) rst_reg <= R_START;
        end
        R_START: if (rph_reg == `OVS_MID) begin
          rph_reg  <= 4'h0;
          rbit_reg <= 3'h0;
          // a glitch shorter than half a bit is dropped
          rst_reg  <= rxl ? R_IDLE : R_DATA;
        end
        R_DATA: if (rph_reg == `OVS_LAST) begin
          rsh_reg  <= {rxl, rsh_reg[7:1]};
          rbit_reg <= rbit_reg + 3'h1;
          if (rbit_reg == nlast)
            rst_reg <= (pm == `P_NONE) ? R_STOP : R_PAR;
        end
        R_PAR: if (rph_reg == `OVS_LAST) begin
          rpb_reg <= rxl;
          rst_reg <= R_STOP;
        end
        R_STOP: if (rph_reg == `OVS_LAST) rst_reg <= R_IDLE;
        default: rst_reg <= R_IDLE;
      endcase
    end
  end

  // overrun tag, timeout counter, level history
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      oep_reg  <= 1'b0;
      rtc_reg  <= 10'h000;
      txok_reg <= 1'b0;
      rxok_reg <= 1'b0;
    end else begin
      txok_reg <= txok;
      rxok_reg <= rxok;
      if (oe_ev) oep_reg <= 1'b1;
      else if (rx_push) oep_reg <= 1'b0;
      // 32 idle bit times with data waiting
      if (rx_empty | rx_pop | (rst_reg != R_IDLE)) rtc_reg <= 10'h000;
      else if (tick_reg & rtc_reg != `RT_LAST)
        rtc_reg <= rtc_reg + 10'h001;
    end
  end
endmodule

// ==== tb/uart_line_peer.sv ====
// remote serial device model: drives the rx line, samples the tx line
`timescale 1ns/1ns
module uart_line_peer (
  // clock
  input  wire logic clk,
  // serial line
  input  wire logic line_in,
  output logic      line_out
);
  int bit_clks = 32;  // clocks per bit at the divisor the bench sets
  // idle line is mark, as a pulled-up wire would be
  initial line_out = 1'b1;
  // send n bits lsb first, each held one bit time
  task automatic send(input logic [11:0] fr, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= fr[i];
      repeat (bit_clks) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
  // wait for a start bit, then sample n bits at their centres
  task automatic grab(input int n, output logic [11:0] fr);
    int k;
    k = 0;
    fr = 12'hFFF;
    @(posedge clk);
    // bounded wait so a silent line cannot hang the run
    while (line_in !== 1'b0 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      fr[i] = line_in;
      repeat (bit_clks) @(posedge clk);
    end
  endtask
endmodule

// ==== tb/uart_core_properties.sv ====
// port assertions of the uart core, bound to its top module
`timescale 1ns/1ns
`include "uart_consts.vh"
module uart_core_props (
  // clock and reset
  input wire logic        MCLK_IN,
  input wire logic        RST_N_IN,
  // apb slave
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  // serial line and interrupt
  input wire logic        RXD_IN,
  input wire logic        TXD_OUT,
  input wire logic        IRQ_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // unaligned or past the last register
  wire hole = PADDR_IN[1:0] != 2'h0 || PADDR_IN > `A_IMSK;
  // setup phase of a transfer
  sequence setup_s;
    PSEL_IN && !PENABLE_IN;
  endsequence
  // access phase that completes
  sequence done_s;
    PSEL_IN && PENABLE_IN && PREADY_OUT;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> PREADY_OUT)
    else $error("ready missing after setup");
  ready_cause_a: assert property (PREADY_OUT |->
    PSEL_IN && PENABLE_IN && $past(PSEL_IN && !PENABLE_IN))
    else $error("ready without a setup");
  ready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held two cycles");
  hole_err_a: assert property (setup_s ##0 hole |=> PSLVERR_OUT)
    else $error("unmapped access without error");
  hole_zero_a: assert property (
    setup_s ##0 (hole && !PWRITE_IN) |=> PRDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  err_cause_a: assert property (done_s ##0 PSLVERR_OUT |->
    hole || (PWRITE_IN && PADDR_IN == `A_DATA))
    else $error("error on a legal access");
  mask_off_a: assert property (done_s ##0 PWRITE_IN
    && PADDR_IN == `A_IMSK && PWDATA_IN[6:0] == 7'h0 |-> ##2 !IRQ_OUT)
    else $error("interrupt with all sources masked");
  reset_idle_a: assert property ($rose(RST_N_IN) |->
    TXD_OUT && !IRQ_OUT && !PREADY_OUT)
    else $error("outputs not idle after reset");
endmodule
bind uart_core_control uart_core_props u_props (.MCLK_IN, .RST_N_IN,
  .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT,
  .PREADY_OUT, .PSLVERR_OUT, .RXD_IN, .TXD_OUT, .IRQ_OUT);

// ==== tb/uart_core_control_bench.sv ====
// self-checking bench of the uart core: apb tasks and line tests
`timescale 1ns/1ns
`include "uart_consts.vh"
module uart_core_control_bench;
  // design inputs, all valued at time zero
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  // design outputs and the line from the peer
  logic [31:0] prdata;
  logic        pready, pslverr, rxd, txd, irq, tprev;
  // bookkeeping
  int          err_total = 0, n_compared = 0, cycles = 0, nb, k;
  logic [31:0] rdat;      // read data of the last transfer
  logic        rerr;      // error flag of the last transfer
  logic [11:0] f, got;    // expected and observed frames
  logic [5:0]  ln;        // line setting under test
  // reset values from 0x08 up to the hole at 0x20
  logic [31:0] rv [7] = '{32'h0, 32'h3, 32'h44, 32'h12, 32'h2, 32'h0, 32'h0};

  always #4 clk = ~clk;
  uart_core_control u_dut (.MCLK_IN(clk), .RST_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RXD_IN(rxd),
    .TXD_OUT(txd), .IRQ_OUT(irq));
  uart_line_peer u_peer (.clk(clk), .line_in(txd), .line_out(rxd));
  // whole run is about 12000 cycles, so this only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      wrap_up;
    end
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      err_total++;
      $display("BAD pready expected 1 seen %b", pready);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next call never reassigns psel in this step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write error", 32'h0, 32'(rerr));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  // frame as sent on the wire, lsb first; nb gets its bit count
  function automatic logic [11:0] mk(input logic [7:0] d, input logic [5:0] l);
    int n;
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - l[1:0]));
    mk = 12'hFFE;
    n = l[1:0] + 5;
    for (int i = 0; i < n; i++)
      mk[i + 1] = m[i];
    n = n + 1;
    if (l[5:3] != 3'h0) begin
      mk[n] = (l[5:3] == 3'h1) ? ^m : (l[5:3] == 3'h2) ? ~^m : l[5:3] == 3'h3;
      n = n + 1;
    end
    nb = n + 1 + l[2];
  endfunction
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'h08 + 8'(4 * i), 32'h0);
      chk("reset value", rv[i], rdat);
      chk("slave error", 32'(i == 6), 32'(rerr));
    end
    wr(`A_BAUD, 32'h2);
    rd(`A_BAUD, 32'h2, "divisor");
    wr(`A_LVL, 32'h1C);
    rd(`A_LVL, 32'h1C, "levels");
    wr(`A_CTRL, 32'h0F);
    rd(`A_CTRL, 32'h0F, "control");
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      ln = {3'(i), 1'(i), 2'(3 - i)};
      wr(`A_LINE, 32'(ln));
      f = mk(8'h96 + 8'(i), ln);
      fork
        wr(`A_DATA, 32'h96 + i);
        u_peer.grab(nb, got);
      join
      chk("tx frame", 32'(f), 32'(got));
    end
    $display("test transmit done");
    wr(`A_LINE, 32'h0B);
    f = mk(8'hC3, 6'h0B);
    u_peer.send(f, nb);
    repeat (4) @(posedge clk);
    rd(`A_STAT, 32'h7, "status");
    rd(`A_DATA, 32'hC3, "rx data");
    rd(`A_STAT, 32'h5, "status");
    wr(`A_IMSK, 32'h10);
    rd(`A_IST, 32'h0, "int status");
    f = mk(8'h3C, 6'h0B);
    f[9] = ~f[9];
    u_peer.send(f, nb);
    repeat (4) @(posedge clk);
    chk("irq", 32'h1, 32'(irq));
    rd(`A_IST, 32'h10, "int status");
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    rd(`A_DATA, 32'h23C, "rx data");
    // all-zero frame: framing and break, then idle until timeout
    u_peer.send(12'h000, 11);
    repeat (1100) @(posedge clk);
    rd(`A_IST, 32'h2C, "int status");
    rd(`A_DATA, 32'h500, "rx data");
    // sixteen frames fill the rx fifo, the seventeenth overruns
    f = mk(8'h5A, 6'h0B);
    for (int i = 0; i < 17; i++) begin
      u_peer.send(f, nb);
      @(posedge clk);
    end
    rd(`A_IST, 32'h41, "int status");
    for (int i = 0; i < 16; i++)
      rd(`A_DATA, 32'h5A, "rx depth");
    rd(`A_STAT, 32'h5, "status");
    $display("test receive done");
    wr(`A_LINE, 32'h03);
    wr(`A_CTRL, 32'h09);
    for (int i = 0; i < 16; i++)
      wr(`A_DATA, 32'h40 + i);
    apb(1'b1, `A_DATA, 32'hEE);
    chk("full refused", 32'h1, 32'(rerr));
    rd(`A_STAT, 32'h0, "status");
    f = mk(8'h40, 6'h03);
    fork
      begin
        wr(`A_CTRL, 32'h0B);
        repeat (60) @(posedge clk);
        wr(`A_CTRL, 32'h00);
      end
      u_peer.grab(nb, got);
    join
    chk("last frame", 32'(f), 32'(got));
    rd(`A_STAT, 32'h5, "status");
    $display("test fifo and disable done");
    wr(`A_CTRL, 32'h41);
    repeat (640) @(posedge clk);
    chk("break line", 32'h0, 32'(txd));
    wr(`A_CTRL, 32'h31);
    chk("sir idle", 32'h0, 32'(txd));
    rd(`A_CTRL, 32'h31, "control");
    wr(`A_CTRL, 32'h21);
    rd(`A_CTRL, 32'h01, "control");
    chk("nrz idle", 32'h1, 32'(txd));
    wr(`A_CTRL, 32'h13);
    wr(`A_DATA, 32'h00);
    k = 0;
    tprev = 1'b0;
    // every zero bit, start included, gives one pulse
    repeat (400) begin
      @(posedge clk);
      if (txd === 1'b1 && tprev === 1'b0)
        k++;
      tprev = txd;
    end
    chk("sir pulses", 32'd9, 32'(k));
    wr(`A_IMSK, 32'h0);
    // low power sir: a lone zero bit gives one fixed-width pulse
    wr(`A_BAUD, 32'h10);
    wr(`A_CTRL, 32'h33);
    wr(`A_DATA, 32'hFF);
    k = 0;
    repeat (300) begin
      @(posedge clk);
      if (txd === 1'b1)
        k++;
    end
    chk("sir short pulse", 32'(`IR_LP_CYC), 32'(k));
    $display("test line modes done");
    wrap_up;
  end
endmodule
